// file: rtl/serial_flash_program_erase.sv
`timescale 1ns/1ps
module serial_flash_program_erase
#(
   parameter int PAGE_WRITE_CYCLES =
      sfpe_pkg::PAGE_WRITE_TIME_US * sfpe_pkg::CLOCK_MHZ,
   parameter int SECTOR_CLEAR_CYCLES =
      sfpe_pkg::SECTOR_CLEAR_TIME_US * sfpe_pkg::CLOCK_MHZ,
   parameter int HALF_BLOCK_CLEAR_CYCLES =
      sfpe_pkg::HALF_BLOCK_CLEAR_TIME_US * sfpe_pkg::CLOCK_MHZ,
   parameter int BLOCK_CLEAR_CYCLES =
      sfpe_pkg::BLOCK_CLEAR_TIME_US * sfpe_pkg::CLOCK_MHZ,
   parameter longint CHIP_CLEAR_CYCLES =
      longint'(sfpe_pkg::CHIP_CLEAR_TIME_US) * sfpe_pkg::CLOCK_MHZ
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic chipSelect_n,
   input wire logic serialClock,
   input wire logic [3:0] dataIn,
   input wire logic fourLineCmdMode,
   input wire logic protectPinDisable,
   input wire logic [3:0] protectLevel,
   input wire logic bootLockEnable,
   input wire logic [23:0] protectedLow,
   input wire logic [23:0] protectedHigh,
   output logic writeEnableLatch,
   output logic writeInProgress,
   output sfpe_pkg::sfpe_word_t pageWord,
   output logic pageWordValid,
   input wire logic pageWordReady,
   output sfpe_pkg::sfpe_erase_t eraseRequest,
   output logic eraseStart
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic csSync;
   logic csActive;
   logic sckSync;
   logic [3:0] dqSync;

   sfpe_sync csSyncer (.clock(clock), .reset_n(reset_n), .in(!chipSelect_n), .out(csActive));
   assign csSync = !csActive;
   sfpe_sync sckSyncer (.clock(clock), .reset_n(reset_n), .in(serialClock), .out(sckSync));
   for (genvar i = 0; i < 4; i++)
   begin : dq
      sfpe_sync dqSyncer (.clock(clock), .reset_n(reset_n), .in(dataIn[i]), .out(dqSync[i]));
   end

   // ****************************************
   // State
   // ****************************************
   localparam int PAGE_BYTES_W = sfpe_pkg::PAGE_BYTES;
   typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_DROP} sfpe_phase_t;

   typedef struct packed {
      logic sckLast;
      logic csLast;
      sfpe_phase_t phase;
      logic [7:0] shift;
      logic [2:0] bitCount;
      logic [1:0] addrCount;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [8:0] byteCount;
      logic quadData;
      logic write_enable_latch;
      logic write_in_progress;
      logic [63:0] timer;
      logic [23:0] pageBase;
      logic [7:0] pageIndex;
      logic [8:0] flushCount;
      logic [PAGE_BYTES_W-1:0][7:0] page;
      logic [PAGE_BYTES_W-1:0] pageMark;
      sfpe_pkg::sfpe_erase_t erase;
      logic eraseStart;
   } sfpe_state_t;

   sfpe_state_t state;
   sfpe_state_t next_state;
   logic bufInValid;
   logic bufInReady;
   sfpe_pkg::sfpe_word_t bufInWord;
   logic sckRise;
   logic csRise;
   logic [7:0] byteNow;
   logic byteDone;
   logic [2:0] stepBits;
   logic [3:0] nibble;
   logic [23:0] eraseBase;
   sfpe_pkg::sfpe_op_t eraseOp;
   logic eraseProtected;
   logic [63:0] cycleLen;

   always_comb
   begin
      next_state = state;
      next_state.sckLast = sckSync;
      next_state.csLast = csSync;
      next_state.eraseStart = 1'b0;
      sckRise = sckSync && !state.sckLast;
      csRise = csSync && !state.csLast;
      // Four lines in quad data or four-line mode; high nibble first
      nibble = dqSync;
      stepBits = (fourLineCmdMode || state.quadData) ? 3'h4 : 3'h1;
      byteNow = (stepBits == 3'h4) ? {state.shift[3:0], nibble} : {state.shift[6:0], dqSync[0]};
      byteDone = sckRise && (3'(state.bitCount + stepBits) == 3'h0);
      eraseOp = sfpe_pkg::SFPE_OP_NONE;
      eraseBase = '0;
      cycleLen = '0;
      bufInValid = 1'b0;
      bufInWord = '0;

      // Self-timed cycle
      if (state.write_in_progress)
      begin
         if (state.flushCount != 9'h0)
         begin
            // Drain staged page bytes; stall here when the array is busy
            bufInValid = state.pageMark[state.pageIndex];
            bufInWord.addr = {state.pageBase[23:8], state.pageIndex};
            bufInWord.data = state.page[state.pageIndex];
            if (!bufInValid || bufInReady)
            begin
               next_state.pageIndex = 8'(state.pageIndex + 8'h1);
               next_state.flushCount = 9'(state.flushCount - 9'h1);
            end
         end
         else if (state.timer != 64'h0)
         begin
            next_state.timer = state.timer - 64'h1;
         end
         else if (!pageWordValid)
         begin
            next_state.write_in_progress = 1'b0;
            next_state.write_enable_latch = 1'b0;
         end
      end

      // Frame decoding
      if (csSync)
      begin
         next_state.phase = ST_IDLE;
         next_state.bitCount = '0;
         next_state.quadData = 1'b0;
      end
      else if (state.phase == ST_IDLE)
      begin
         next_state.phase = state.write_in_progress ? ST_DROP : ST_OPCODE;
         next_state.pageMark = state.write_in_progress ? state.pageMark : '0;
         next_state.byteCount = '0;
      end
      if (!csSync && sckRise && state.phase != ST_IDLE && state.phase != ST_DROP)
      begin
         next_state.shift = byteNow;
         next_state.bitCount = 3'(state.bitCount + stepBits);
         if (byteDone)
         begin
            case (state.phase)
               ST_OPCODE:
               begin
                  next_state.opcode = byteNow;
                  next_state.addrCount = '0;
                  if (byteNow == sfpe_pkg::OP_QUAD_PAGE && !fourLineCmdMode)
                  begin
                     next_state.phase = ST_ADDR;
                     next_state.quadData = 1'b1;
                  end
                  else if (byteNow == sfpe_pkg::OP_SECTOR_CLEAR
                     || byteNow == sfpe_pkg::OP_HALF_BLOCK_CLEAR
                     || byteNow == sfpe_pkg::OP_BLOCK_CLEAR)
                  begin
                     next_state.phase = ST_ADDR;
                  end
                  else
                  begin
                     next_state.phase = ST_DATA;
                  end
               end
               ST_ADDR:
               begin
                  next_state.addr = {state.addr[15:0], byteNow};
                  next_state.addrCount = 2'(state.addrCount + 2'h1);
                  next_state.byteCount = '0;
                  if (2'(state.addrCount + 2'h1) == 2'(sfpe_pkg::ADDR_BYTES))
                  begin
                     next_state.phase = ST_DATA;
                  end
               end
               default:
               begin
                  // Page data: index wraps; later bytes overwrite earlier
                  next_state.page[8'(state.addr[7:0] + state.byteCount[7:0])] = byteNow;
                  next_state.pageMark[8'(state.addr[7:0] + state.byteCount[7:0])] = 1'b1;
                  next_state.byteCount = (state.byteCount == 9'h1FF) ? 9'h100
                     : 9'(state.byteCount + 9'h1);
               end
            endcase
         end
      end

      // Select rise ends the frame; bitCount 0 means byte aligned
      if (csRise && state.phase != ST_IDLE && state.bitCount == 3'h0 && !state.write_in_progress)
      begin
         if (state.phase == ST_DATA && state.opcode == sfpe_pkg::OP_WRITE_UNLOCK
            && state.byteCount == 9'h0)
         begin
            next_state.write_enable_latch = 1'b1;
         end
         else if (state.write_enable_latch)
         begin
            if (state.opcode == sfpe_pkg::OP_QUAD_PAGE && state.phase == ST_DATA
               && state.byteCount != 9'h0 && protectPinDisable && state.quadData)
            begin
               eraseOp = sfpe_pkg::SFPE_OP_PAGE;
               cycleLen = 64'(PAGE_WRITE_CYCLES);
            end
            else if (state.phase == ST_DATA && state.byteCount == 9'h0)
            begin
               if (state.opcode == sfpe_pkg::OP_SECTOR_CLEAR)
               begin
                  eraseOp = sfpe_pkg::SFPE_OP_SECTOR;
                  eraseBase = state.addr & sfpe_pkg::SECTOR_MASK;
                  cycleLen = 64'(SECTOR_CLEAR_CYCLES);
               end
               else if (state.opcode == sfpe_pkg::OP_HALF_BLOCK_CLEAR)
               begin
                  eraseOp = sfpe_pkg::SFPE_OP_HALF;
                  eraseBase = state.addr & sfpe_pkg::HALF_BLOCK_MASK;
                  cycleLen = 64'(HALF_BLOCK_CLEAR_CYCLES);
               end
               else if (state.opcode == sfpe_pkg::OP_BLOCK_CLEAR)
               begin
                  eraseOp = sfpe_pkg::SFPE_OP_BLOCK;
                  eraseBase = state.addr & sfpe_pkg::BLOCK_MASK;
                  cycleLen = 64'(BLOCK_CLEAR_CYCLES);
               end
               else if ((state.opcode == sfpe_pkg::OP_CHIP_CLEAR_A
                  || state.opcode == sfpe_pkg::OP_CHIP_CLEAR_B)
                  && state.addrCount == 2'h0)
               begin
                  eraseOp = sfpe_pkg::SFPE_OP_CHIP;
                  cycleLen = 64'(CHIP_CLEAR_CYCLES);
               end
            end
         end
      end

      // Protection: page and region erase checked against the locked range
      eraseProtected = 1'b0;
      if (eraseOp == sfpe_pkg::SFPE_OP_CHIP)
      begin
         eraseProtected = (protectLevel != sfpe_pkg::PROTECT_NONE) || bootLockEnable;
      end
      else if (eraseOp != sfpe_pkg::SFPE_OP_NONE)
      begin
         eraseProtected = (protectLevel != sfpe_pkg::PROTECT_NONE || bootLockEnable)
            && (state.addr >= protectedLow) && (state.addr <= protectedHigh);
      end
      if (eraseOp != sfpe_pkg::SFPE_OP_NONE && !eraseProtected)
      begin
         next_state.write_in_progress = 1'b1;
         next_state.timer = cycleLen;
         if (eraseOp == sfpe_pkg::SFPE_OP_PAGE)
         begin
            next_state.pageBase = state.addr;
            next_state.pageIndex = '0;
            next_state.flushCount = 9'h100;
         end
         else
         begin
            next_state.erase.op = eraseOp;
            next_state.erase.base = eraseBase;
            next_state.eraseStart = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= '0;
         state.csLast <= 1'b1;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ****************************************
   // Array write buffer
   // ****************************************
   // Absorbs array stalls so no staged byte is lost
   sfpe_buffer pageBuffer
   (
      .clock(clock),
      .reset_n(reset_n),
      .inWord(bufInWord),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .outWord(pageWord),
      .outValid(pageWordValid),
      .outReady(pageWordReady)
   );

   assign writeEnableLatch = state.write_enable_latch;
   assign writeInProgress = state.write_in_progress;
   assign eraseRequest = state.erase;
   assign eraseStart = state.eraseStart;
endmodule

// file: rtl/sfpe_buffer.sv
`timescale 1ns/1ps
module sfpe_buffer
(
   input wire logic clock,
   input wire logic reset_n,
   input wire sfpe_pkg::sfpe_word_t inWord,
   input wire logic inValid,
   output logic inReady,
   output sfpe_pkg::sfpe_word_t outWord,
   output logic outValid,
   input wire logic outReady
);
   // ****************************************
   // Two-entry buffer
   // ****************************************
   typedef struct packed {
      sfpe_pkg::sfpe_word_t [1:0] slot;
      logic rdPtr;
      logic wrPtr;
      logic [1:0] count;
   } sfpe_buffer_t;

   sfpe_buffer_t state;
   sfpe_buffer_t next_state;
   logic push;
   logic pop;

   always_comb
   begin
      next_state = state;
      push = inValid && (state.count != 2'h2);
      pop = outReady && (state.count != 2'h0);
      if (push)
      begin
         next_state.slot[state.wrPtr] = inWord;
         next_state.wrPtr = ~state.wrPtr;
      end
      if (pop)
      begin
         next_state.rdPtr = ~state.rdPtr;
      end
      next_state.count = 2'(state.count + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign inReady = state.count != 2'h2;
   assign outValid = state.count != 2'h0;
   assign outWord = state.slot[state.rdPtr];
endmodule

// file: rtl/sfpe_pkg.sv
package sfpe_pkg;
   // ****************************************
   // Opcodes
   // ****************************************
   localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] OP_QUAD_PAGE = 8'h32;
   localparam logic [7:0] OP_SECTOR_CLEAR = 8'h20;
   localparam logic [7:0] OP_HALF_BLOCK_CLEAR = 8'h52;
   localparam logic [7:0] OP_BLOCK_CLEAR = 8'hD8;
   localparam logic [7:0] OP_CHIP_CLEAR_A = 8'hC7;
   localparam logic [7:0] OP_CHIP_CLEAR_B = 8'h60;

   // ****************************************
   // Geometry and counts
   // ****************************************
   localparam int ADDR_W = 24;
   localparam int PAGE_BYTES = 256;
   localparam logic [2:0] ADDR_BYTES = 3'h3;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [23:0] SECTOR_MASK = 24'hFF_F000;
   localparam logic [23:0] HALF_BLOCK_MASK = 24'hFF_8000;
   localparam logic [23:0] BLOCK_MASK = 24'hFF_0000;
   localparam logic [3:0] PROTECT_NONE = 4'h0;

   // ****************************************
   // Self-timed cycle lengths
   // ****************************************
   localparam int CLOCK_MHZ = 40;
   localparam int PAGE_WRITE_TIME_US = 500;
   localparam int SECTOR_CLEAR_TIME_US = 40000;
   localparam int HALF_BLOCK_CLEAR_TIME_US = 200000;
   localparam int BLOCK_CLEAR_TIME_US = 300000;
   localparam int CHIP_CLEAR_TIME_US = 60000000;
   localparam int CYCLE_W = 32;

   typedef enum logic [2:0] {
      SFPE_OP_NONE,
      SFPE_OP_PAGE,
      SFPE_OP_SECTOR,
      SFPE_OP_HALF,
      SFPE_OP_BLOCK,
      SFPE_OP_CHIP
   } sfpe_op_t;

   // Byte written into the array
   typedef struct packed {
      logic [23:0] addr;
      logic [7:0] data;
   } sfpe_word_t;

   // Erase request to the array
   typedef struct packed {
      sfpe_op_t op;
      logic [23:0] base;
   } sfpe_erase_t;
endpackage

// file: rtl/sfpe_sync.sv
`timescale 1ns/1ps
module sfpe_sync
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic in,
   output logic out
);
   typedef struct packed {
      logic first;
      logic second;
   } sfpe_sync_t;

   sfpe_sync_t state;
   sfpe_sync_t next_state;

   always_comb
   begin
      next_state.first = in;
      next_state.second = state.first;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign out = state.second;
endmodule

// file: tb/serial_flash_program_erase_tb.sv
`timescale 1ns/1ps
module serial_flash_program_erase_tb;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic chipSelect_n, serialClock, writeEnableLatch, writeInProgress;
   logic [3:0] dataIn;
   logic fourLineCmdMode = 1'b0;
   logic protectPinDisable = 1'b0;
   logic [3:0] protectLevel = 4'h0;
   logic bootLockEnable = 1'b0;
   logic [23:0] protectedLow = 24'h10_0000;
   logic [23:0] protectedHigh = 24'h1F_FFFF;
   logic pageWordReady = 1'b0;
   logic pageWordValid, eraseStart;
   sfpe_pkg::sfpe_word_t pageWord;
   sfpe_pkg::sfpe_erase_t eraseRequest;
   int err_total = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [31:0] seenQ[$];
   logic [31:0] expQ[$];
   initial
   begin
      forever #12.5 clock = ~clock;
   end
   sfpe_host_model host (.clock(clock), .chipSelect_n(chipSelect_n),
      .serialClock(serialClock), .dataIn(dataIn));
   serial_flash_program_erase #(.PAGE_WRITE_CYCLES(20), .SECTOR_CLEAR_CYCLES(600),
      .HALF_BLOCK_CLEAR_CYCLES(20), .BLOCK_CLEAR_CYCLES(20), .CHIP_CLEAR_CYCLES(20)) dut
   (
      .clock(clock), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
      .serialClock(serialClock), .dataIn(dataIn), .fourLineCmdMode(fourLineCmdMode),
      .protectPinDisable(protectPinDisable), .protectLevel(protectLevel),
      .bootLockEnable(bootLockEnable), .protectedLow(protectedLow),
      .protectedHigh(protectedHigh), .writeEnableLatch(writeEnableLatch),
      .writeInProgress(writeInProgress), .pageWord(pageWord),
      .pageWordValid(pageWordValid), .pageWordReady(pageWordReady),
      .eraseRequest(eraseRequest), .eraseStart(eraseStart)
   );
   task automatic final_report();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Random stalls at the array side; results gathered for the model
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      pageWordReady <= ($urandom % 4) != 0;
      if (eraseStart === 1'b1)
         seenQ.push_back({5'h00, eraseRequest});
      if (pageWordValid === 1'b1 && pageWordReady === 1'b1)
         seenQ.push_back(pageWord);
      if (cycles == 60000)
      begin
         err_total++;
         final_report();
      end
   end
   task automatic settle();
      int n;
      n = 0;
      repeat (12) @(posedge clock);
      while (writeInProgress !== 1'b0 && n < 20000)
      begin
         @(posedge clock);
         n++;
      end
      repeat (2) @(posedge clock);
   endtask
   task automatic unlock(input int qf);
      host.send('{sfpe_pkg::OP_WRITE_UNLOCK}, qf, 0);
      settle();
      check(writeEnableLatch, 1'b1);
   endtask
   task automatic run(input logic [7:0] q[$], input int qf, input int extra);
      host.send(q, qf, extra);
      settle();
      check(seenQ.size(), expQ.size());
      while (expQ.size() > 0 && seenQ.size() > 0)
         check(seenQ.pop_front(), expQ.pop_front());
      seenQ.delete();
      expQ.delete();
   endtask
   initial
   begin
      logic [23:0] a;
      logic [7:0] d;
      logic [7:0] ops[5];
      sfpe_pkg::sfpe_op_t kinds[5];
      logic [23:0] masks[5];
      logic [7:0] expMap[int];
      int qf;
      void'($urandom(32'hf3e3));
      ops = '{sfpe_pkg::OP_SECTOR_CLEAR, sfpe_pkg::OP_HALF_BLOCK_CLEAR,
         sfpe_pkg::OP_BLOCK_CLEAR, sfpe_pkg::OP_CHIP_CLEAR_A, sfpe_pkg::OP_CHIP_CLEAR_B};
      kinds = '{sfpe_pkg::SFPE_OP_SECTOR, sfpe_pkg::SFPE_OP_HALF, sfpe_pkg::SFPE_OP_BLOCK,
         sfpe_pkg::SFPE_OP_CHIP, sfpe_pkg::SFPE_OP_CHIP};
      masks = '{sfpe_pkg::SECTOR_MASK, sfpe_pkg::HALF_BLOCK_MASK, sfpe_pkg::BLOCK_MASK,
         24'h00_0000, 24'h00_0000};
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      repeat (8) @(posedge clock);
      run('{ops[0], 8'h12, 8'h34, 8'h56}, 99, 0);
      for (int m = 0; m < 2; m++)
         for (int k = 0; k < 5; k++)
         begin
            fourLineCmdMode <= m[0];
            qf = m ? 0 : 99;
            a = 24'($urandom);
            unlock(qf);
            expQ.push_back({5'h00, kinds[k], a & masks[k]});
            if (k < 3)
               run('{ops[k], a[23:16], a[15:8], a[7:0]}, qf, 0);
            else
               run('{ops[k]}, qf, 0);
            check(writeEnableLatch, 1'b0);
         end
      fourLineCmdMode <= 1'b0;
      unlock(99);
      run('{ops[0], 8'h01, 8'h02, 8'h03}, 99, 4);
      run('{ops[3]}, 99, 8);
      protectLevel <= 4'h1;
      run('{ops[1], 8'h12, 8'h34, 8'h56}, 99, 0);
      protectedLow <= 24'h00_0000;
      protectedHigh <= 24'h0F_FFFF;
      expQ.push_back({5'h00, kinds[1], 24'h12_3456 & masks[1]});
      run('{ops[1], 8'h12, 8'h34, 8'h56}, 99, 0);
      unlock(99);
      run('{ops[4]}, 99, 0);
      protectLevel <= 4'h0;
      bootLockEnable <= 1'b1;
      run('{ops[3]}, 99, 0);
      bootLockEnable <= 1'b0;
      run('{sfpe_pkg::OP_QUAD_PAGE, 8'h00, 8'h01, 8'h00, 8'h5A}, 1, 0);
      protectPinDisable <= 1'b1;
      run('{sfpe_pkg::OP_QUAD_PAGE, 8'h00, 8'h01, 8'h00, 8'h5A}, 1, 1);
      fourLineCmdMode <= 1'b1;
      run('{sfpe_pkg::OP_QUAD_PAGE, 8'h00, 8'h01, 8'h00, 8'h5A}, 0, 0);
      check(writeEnableLatch, 1'b1);
      fourLineCmdMode <= 1'b0;
      a = 24'($urandom);
      expQ.push_back({5'h00, kinds[0], a & masks[0]});
      host.send('{ops[0], a[23:16], a[15:8], a[7:0]}, 99, 0);
      run('{ops[2], 8'h00, 8'h00, 8'h00}, 99, 0);
      // Fresh page, so its bytes are still erased
      a = {16'($urandom), 8'hF0};
      unlock(99);
      q_build : begin
         logic [7:0] q[$];
         q = '{sfpe_pkg::OP_QUAD_PAGE, a[23:16], a[15:8], a[7:0]};
         for (int j = 0; j < 260; j++)
         begin
            d = 8'($urandom);
            q.push_back(d);
            expMap[(240 + j) % 256] = d;
         end
         foreach (expMap[i])
            expQ.push_back({a[23:8], 8'(i), expMap[i]});
         run(q, 1, 0);
      end
      check(writeEnableLatch, 1'b0);
      final_report();
   end
endmodule

// file: tb/sfpe_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host serial controller
// ****************************************
module sfpe_host_model
(
   input wire logic clock,
   output logic chipSelect_n,
   output logic serialClock,
   output logic [3:0] dataIn
);
   logic busy = 1'b0;
   initial
   begin
      chipSelect_n = 1'b1;
      serialClock = 1'b0;
      dataIn = 4'h5;
   end
   // Released lines toggle, stale data never looks valid
   always @(posedge clock)
   begin
      if (!busy)
         dataIn <= ~dataIn;
   end
   // One 200 ns link clock period per bit or nibble
   task automatic tick(input logic [3:0] v);
      dataIn <= v;
      repeat (4) @(posedge clock);
      serialClock <= 1'b1;
      repeat (4) @(posedge clock);
      serialClock <= 1'b0;
   endtask
   // Bytes from quadFrom on go as nibbles; extra breaks framing
   task automatic send(input logic [7:0] q[$], input int quadFrom, input int extra);
      busy = 1'b1;
      chipSelect_n <= 1'b0;
      @(posedge clock);
      foreach (q[i])
      begin
         if (i >= quadFrom)
         begin
            tick(q[i][7:4]);
            tick(q[i][3:0]);
         end
         else
            for (int b = 7; b >= 0; b--)
               tick({3'h0, q[i][b]});
      end
      repeat (extra) tick(4'hA);
      repeat (4) @(posedge clock);
      chipSelect_n <= 1'b1;
      // Deselect gap, so back-to-back frames never merge
      repeat (8) @(posedge clock);
      busy = 1'b0;
   endtask
endmodule

// file: tb/sfpe_properties.sv
`timescale 1ns/1ps
module sfpe_properties
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic chipSelect_n,
   input wire logic [3:0] protectLevel,
   input wire logic bootLockEnable,
   input wire logic writeEnableLatch,
   input wire logic writeInProgress,
   input wire sfpe_pkg::sfpe_word_t pageWord,
   input wire logic pageWordValid,
   input wire logic pageWordReady,
   input wire sfpe_pkg::sfpe_erase_t eraseRequest,
   input wire logic eraseStart
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   logic [23:0] base;
   sfpe_pkg::sfpe_op_t op;
   assign base = eraseRequest.base;
   assign op = eraseRequest.op;
   // ****************************************
   // Properties
   // ****************************************
   AST_START_RAISES_WIP: assert property (eraseStart |-> ##[0:1] writeInProgress[*2])
      else $error("erase start without busy");
   AST_START_NEEDS_WEL: assert property (eraseStart |-> writeEnableLatch)
      else $error("erase start without latch");
   AST_NO_START_BUSY: assert property (eraseStart |-> !$past(writeInProgress, 2))
      else $error("erase start while busy");
   AST_WEL_CLEARS: assert property ($fell(writeInProgress) |-> !writeEnableLatch)
      else $error("latch still set after cycle");
   AST_WIP_NEEDS_WEL: assert property ($rose(writeInProgress) |-> $past(writeEnableLatch))
      else $error("cycle started without latch");
   AST_CHIP_FREE: assert property (eraseStart && op == sfpe_pkg::SFPE_OP_CHIP |->
      $past(protectLevel) == sfpe_pkg::PROTECT_NONE && !$past(bootLockEnable))
      else $error("chip erase while protected");
   AST_SECTOR_BASE: assert property (eraseStart && op == sfpe_pkg::SFPE_OP_SECTOR |->
      (base & ~sfpe_pkg::SECTOR_MASK) == 24'h00_0000) else $error("sector base");
   AST_HALF_BASE: assert property (eraseStart && op == sfpe_pkg::SFPE_OP_HALF |->
      (base & ~sfpe_pkg::HALF_BLOCK_MASK) == 24'h00_0000) else $error("half base");
   AST_BLOCK_BASE: assert property (eraseStart && op == sfpe_pkg::SFPE_OP_BLOCK |->
      (base & ~sfpe_pkg::BLOCK_MASK) == 24'h00_0000) else $error("block base");
   AST_START_PULSE: assert property (eraseStart |=> !eraseStart)
      else $error("erase start too long");
   AST_START_AFTER_CS: assert property (eraseStart |-> $past(chipSelect_n) && chipSelect_n)
      else $error("erase start inside frame");
   AST_WORD_HELD: assert property (pageWordValid && !pageWordReady |=>
      pageWordValid && $stable(pageWord)) else $error("stalled word lost");
   AST_WORD_IN_CYCLE: assert property (pageWordValid |-> writeInProgress)
      else $error("array word outside cycle");
   // Stall holds the word in the buffer, a drop here would lose a byte
   COV_CHIP: cover property (eraseStart && op == sfpe_pkg::SFPE_OP_CHIP);
   COV_STALL: cover property (pageWordValid && !pageWordReady);
   COV_DONE: cover property ($fell(writeInProgress));
endmodule
bind serial_flash_program_erase sfpe_properties chk
(
   .clock(clock), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
   .protectLevel(protectLevel), .bootLockEnable(bootLockEnable),
   .writeEnableLatch(writeEnableLatch), .writeInProgress(writeInProgress),
   .pageWord(pageWord), .pageWordValid(pageWordValid), .pageWordReady(pageWordReady),
   .eraseRequest(eraseRequest), .eraseStart(eraseStart)
);
